// [verilog/branch_exec_pkg.sv]
/*
  constants, register map and types shared by the instruction executor.
  assumes a 32-bit ahb-lite register bus and word-aligned registers.
*/
`default_nettype none
package branch_exec_pkg;
  // =========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSTR  = 8'h04;
  localparam logic [7:0] ADDR_PC     = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_WREG   = 8'h10;
  localparam logic [7:0] ADDR_BANK   = 8'h14;
  localparam logic [7:0] ADDR_SHADOW = 8'h18;
  localparam logic [7:0] ADDR_STACK  = 8'h1c;
  localparam logic [7:0] ADDR_FSR2   = 8'h20;
  // =========================================================
  // field positions
  localparam int CTRL_EXT_BIT   = 0;
  localparam int FLAG_Z_BIT     = 2;
  localparam int FLAG_OV_BIT    = 3;
  localparam int STAT_BUSY_BIT  = 8;
  localparam int STAT_WAIT2_BIT = 9;
  localparam int SHD_FLAGS_LSB  = 8;
  localparam int SHD_BANK_LSB   = 16;
  // =========================================================
  // widths and reset values
  localparam int PC_W    = 21;
  localparam int FADDR_W = 12;
  localparam int FLAGS_W = 5;
  localparam int BANK_W  = 4;
  localparam logic [PC_W-1:0]    PC_RST    = 21'h000000;
  localparam logic [FLAGS_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [7:0]         WREG_RST  = 8'h00;
  localparam logic [BANK_W-1:0]  BANK_RST  = 4'h0;
  localparam logic [FADDR_W-1:0] FSR2_RST  = 12'h000;
  // =========================================================
  // opcodes and addressing constants
  localparam logic [7:0] OP_BR_OV = 8'he4;
  localparam logic [7:0] OP_BR_Z  = 8'he0;
  localparam logic [6:0] OP_CALL  = 7'h76;
  localparam logic [6:0] OP_CLEAR = 7'h35;
  localparam logic [3:0] OP_CALL2 = 4'hf;
  localparam logic [7:0] IDX_MAX      = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  // =========================================================
  // types
  typedef enum logic [1:0] {st_idle, st_exec, st_nop} exec_state_type;
endpackage
`default_nettype wire

// [verilog/decode_bus.sv]
/*
  decoded instruction fields passed from the decoder to the executor.
  assumes one decoder producer and one executor consumer.
*/
`default_nettype none
interface decode_bus;
  logic       is_br_ov;
  logic       is_br_z;
  logic       is_call;
  logic       is_clear;
  logic       is_call2;
  logic [7:0] lit_low;
  logic       shadow_sel;
  logic       access_sel;
  logic [11:0] k_high;
  modport dec (output is_br_ov, is_br_z, is_call, is_clear, is_call2,
               lit_low, shadow_sel, access_sel, k_high);
  modport exe (input is_br_ov, is_br_z, is_call, is_clear, is_call2,
               lit_low, shadow_sel, access_sel, k_high);
endinterface
`default_nettype wire

// [verilog/instr_decode.sv]
/*
  combinational decoder for the first and second instruction words.
  assumes both words are held stable by the executor.
*/
`default_nettype none
module instr_decode
  import branch_exec_pkg::*;
(
  input  wire logic [15:0] word1,
  input  wire logic [15:0] word2,
  decode_bus.dec           d
);
  // =========================================================
  // field extraction
  always_comb
  begin
    d.is_br_ov   = (word1[15:8] == OP_BR_OV); // see RULE_01
    d.is_br_z    = (word1[15:8] == OP_BR_Z);  // see RULE_02
    d.is_call    = (word1[15:9] == OP_CALL);  // see RULE_06
    d.is_clear   = (word1[15:9] == OP_CLEAR); // see RULE_12
    d.is_call2   = (word2[15:12] == OP_CALL2); // see RULE_06
    d.lit_low    = word1[7:0];
    d.shadow_sel = word1[8];
    d.access_sel = word1[8];
    d.k_high     = word2[11:0];
  end
endmodule // instr_decode
`default_nettype wire

// [verilog/phase_gen.sv]
/*
  four-phase counter of the instruction cycle.
  assumes a synchronised active-low reset and a same-domain clock enable.
*/
`default_nettype none
module phase_gen
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       hold,
  output var  logic [1:0] q
);
  logic [1:0] next_q;

  always_comb
  begin
    next_q = q;
    if (ce)
    begin
      if (!run)
        next_q = 2'h0;
      else if (!hold)
        next_q = q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= 2'h0;
    else
      q <= next_q;
  end
endmodule // phase_gen
`default_nettype wire

// [verilog/branch_call_clear_exec.sv]
/*
  executor for overflow/zero branches, two-word subroutine call and file
  clear, with its architectural registers behind an ahb-lite slave.
  assumes one ahb-lite master, word transfers only, and a data memory that
  takes the clear strobe with its 12-bit address.
*/
// How it works
// RULE_01: overflow branch, prefix e4, signed 8-bit offset, branches only if OV set.
// RULE_02: zero branch, prefix e0, signed 8-bit offset, branches only if Z set.
// RULE_03: taken branch target is incremented counter plus twice the offset.
// RULE_04: taken branch lasts two cycles, second all idle; untaken takes one.
// RULE_05: untaken branch leaves counter at next instruction, no phase-four write.
// RULE_06: call decoded from word 1110110s kkkkkkkk and word 1111 kkkk kkkk kkkk; the executor ignores is_call2 and takes any second word.
// RULE_07: call pushes address of call plus four onto return stack top.
// RULE_08: call with s set copies W, flags and bank select to shadows.
// RULE_09: call with s clear leaves all three shadow registers unchanged.
// RULE_10: call loads 20-bit literal into counter bits 20 to 1.
// RULE_11: call pushes in phase three, writes counter in phase four, then idles.
// RULE_12: clear writes zero to file register, sets Z only, one cycle.
// RULE_13: clear with a=0 uses access bank, a=1 uses bank select register.
// RULE_14: extended set, a=0, address up to 5Fh: clear is indexed by FSR2.
// RULE_15: branches and call leave every status flag untouched.
`default_nettype none
module branch_call_clear_exec
  import branch_exec_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output var  logic [31:0]        hrdata,
  output var  logic               hreadyout,
  output var  logic               hresp,
  output var  logic               mem_clear_en,
  output var  logic [FADDR_W-1:0] mem_clear_addr,
  output var  logic               stack_push
);
  // =========================================================
  // reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // =========================================================
  // state
  exec_state_type       state;
  logic [15:0]          ir;
  logic [15:0]          ir2;
  logic                 ir2_valid;
  logic [PC_W-1:0]      pc;
  logic [FLAGS_W-1:0]   flags;
  logic [7:0]           wreg;
  logic [BANK_W-1:0]    bank_select_reg;
  logic [7:0]           working_shadow;
  logic [FLAGS_W-1:0]   flags_shadow;
  logic [BANK_W-1:0]    bank_select_shadow;
  logic [PC_W-1:0]      return_stack_top;
  logic [FADDR_W-1:0]   fsr2;
  logic                 ext_en;
  logic                 wr_pend;
  logic [7:0]           wr_addr;

  exec_state_type       next_state;
  logic [15:0]          next_ir;
  logic [15:0]          next_ir2;
  logic                 next_ir2_valid;
  logic [PC_W-1:0]      next_pc;
  logic [FLAGS_W-1:0]   next_flags;
  logic [7:0]           next_wreg;
  logic [BANK_W-1:0]    next_bank_select_reg;
  logic [7:0]           next_working_shadow;
  logic [FLAGS_W-1:0]   next_flags_shadow;
  logic [BANK_W-1:0]    next_bank_select_shadow;
  logic [PC_W-1:0]      next_return_stack_top;
  logic [FADDR_W-1:0]   next_fsr2;
  logic                 next_ext_en;
  logic                 next_wr_pend;
  logic [7:0]           next_wr_addr;
  logic [31:0]          next_hrdata;
  logic                 next_mem_clear_en;
  logic [FADDR_W-1:0]   next_mem_clear_addr;
  logic                 next_stack_push;

  logic [1:0]           q;
  logic                 wait2;
  logic                 busy;
  logic                 taken;
  logic [FADDR_W-1:0]   clr_addr;
  logic                 wr_now;

  decode_bus dec_bus ();

  instr_decode u_decode
  (
    .word1 (ir),
    .word2 (ir2),
    .d     (dec_bus)
  );

  // call stalls in phase four until its second word arrives
  assign wait2 = (state == st_exec) && dec_bus.is_call && (q == Q_LAST)
                 && !ir2_valid;
  assign busy  = (state != st_idle);

  phase_gen u_phase
  (
    .core_clk (core_clk),
    .rst_n    (rst_sync_n),
    .ce       (ce),
    .run      (busy),
    .hold     (wait2),
    .q        (q)
  );

  // =========================================================
  // condition and clear address
  always_comb
  begin
    taken = (dec_bus.is_br_ov && flags[FLAG_OV_BIT]) // see RULE_01
         || (dec_bus.is_br_z && flags[FLAG_Z_BIT]);  // see RULE_02
    if (!dec_bus.access_sel && ext_en && (dec_bus.lit_low <= IDX_MAX))
      clr_addr = fsr2 + {4'h0, dec_bus.lit_low};         // see RULE_14
    else if (!dec_bus.access_sel)
      clr_addr = (dec_bus.lit_low < ACCESS_SPLIT)
               ? {4'h0, dec_bus.lit_low}                 // see RULE_13
               : {ACCESS_HI_BANK, dec_bus.lit_low};
    else
      clr_addr = {bank_select_reg, dec_bus.lit_low};     // see RULE_13
  end

  // =========================================================
  // register bus read mux, sampled at the address phase
  assign wr_now = wr_pend;

  always_comb
  begin
    next_hrdata = 32'h00000000;
    case (haddr[7:0])
      ADDR_CTRL:   next_hrdata[CTRL_EXT_BIT] = ext_en;
      ADDR_INSTR:  next_hrdata = {ir2, ir};
      ADDR_PC:     next_hrdata[PC_W-1:0] = pc;
      ADDR_STATUS:
      begin
        next_hrdata[FLAGS_W-1:0]    = flags;
        next_hrdata[STAT_BUSY_BIT]  = busy;
        next_hrdata[STAT_WAIT2_BIT] = wait2;
      end
      ADDR_WREG:   next_hrdata[7:0] = wreg;
      ADDR_BANK:   next_hrdata[BANK_W-1:0] = bank_select_reg;
      ADDR_SHADOW:
      begin
        next_hrdata[7:0] = working_shadow;
        next_hrdata[SHD_FLAGS_LSB +: FLAGS_W] = flags_shadow;
        next_hrdata[SHD_BANK_LSB +: BANK_W] = bank_select_shadow;
      end
      ADDR_STACK:  next_hrdata[PC_W-1:0] = return_stack_top;
      ADDR_FSR2:   next_hrdata[FADDR_W-1:0] = fsr2;
      default:     next_hrdata = 32'h00000000;
    endcase
    if (haddr[31:8] != 24'h000000)
      next_hrdata = 32'h00000000;
  end

  // =========================================================
  // execution and register writes
  always_comb
  begin
    next_state              = state;
    next_ir                 = ir;
    next_ir2                = ir2;
    next_ir2_valid          = ir2_valid;
    next_pc                 = pc;
    next_flags              = flags;
    next_wreg               = wreg;
    next_bank_select_reg    = bank_select_reg;
    next_working_shadow     = working_shadow;
    next_flags_shadow       = flags_shadow;
    next_bank_select_shadow = bank_select_shadow;
    next_return_stack_top   = return_stack_top;
    next_fsr2               = fsr2;
    next_ext_en             = ext_en;
    next_wr_pend            = wr_pend;
    next_wr_addr            = wr_addr;
    next_mem_clear_en       = mem_clear_en;
    next_mem_clear_addr     = mem_clear_addr;
    next_stack_push         = stack_push;
    if (ce)
    begin
      next_mem_clear_en = 1'b0;
      next_stack_push   = 1'b0;
      next_wr_pend = hsel && htrans[1] && hready && hwrite
                     && (haddr[31:8] == 24'h000000);
      next_wr_addr = haddr[7:0];
      // bus writes, data phase of a taken write
      if (wr_now && (wr_addr == ADDR_INSTR))
      begin
        if (state == st_idle)
        begin
          next_ir        = hwdata[15:0];
          next_ir2_valid = 1'b0;
          next_state     = st_exec;
        end
        else if ((state == st_exec) && dec_bus.is_call && !ir2_valid)
        begin
          next_ir2       = hwdata[15:0];
          next_ir2_valid = 1'b1;
        end
      end
      else if (wr_now && (state == st_idle))
      begin
        case (wr_addr)
          ADDR_CTRL:   next_ext_en = hwdata[CTRL_EXT_BIT];
          ADDR_PC:     next_pc = {hwdata[PC_W-1:1], 1'b0};
          ADDR_STATUS: next_flags = hwdata[FLAGS_W-1:0];
          ADDR_WREG:   next_wreg = hwdata[7:0];
          ADDR_BANK:   next_bank_select_reg = hwdata[BANK_W-1:0];
          ADDR_FSR2:   next_fsr2 = hwdata[FADDR_W-1:0];
          default:     next_ext_en = ext_en;
        endcase
      end
      // instruction phases
      case (state)
        st_idle:
          next_state = next_state;
        st_exec:
        begin
          case (q)
            2'h0:
              next_pc = pc + PC_STEP;                   // see RULE_05
            2'h2:
              if (dec_bus.is_call)
              begin
                next_return_stack_top = pc + PC_STEP;   // see RULE_07
                next_stack_push       = 1'b1;           // see RULE_11
                if (dec_bus.shadow_sel)                 // see RULE_08
                begin
                  next_working_shadow     = wreg;
                  next_flags_shadow       = flags;
                  next_bank_select_shadow = bank_select_reg;
                end                                     // see RULE_09
              end
            2'h3:
            begin
              next_state = st_idle;                     // see RULE_04
              if ((dec_bus.is_br_ov || dec_bus.is_br_z) && taken)
              begin
                next_pc = pc + {{12{dec_bus.lit_low[7]}}, // see RULE_03
                                dec_bus.lit_low, 1'b0};
                next_state = st_nop;                    // see RULE_04
              end
              else if (dec_bus.is_call)
              begin
                if (ir2_valid)
                begin
                  next_pc = {dec_bus.k_high,             // see RULE_10
                             dec_bus.lit_low, 1'b0};
                  next_state = st_nop;                  // see RULE_11
                end
                else
                  next_state = st_exec;
              end
              else if (dec_bus.is_clear)
              begin
                next_mem_clear_en   = 1'b1;             // see RULE_12
                next_mem_clear_addr = clr_addr;
                next_flags[FLAG_Z_BIT] = 1'b1;          // see RULE_12
              end
            end
            default:
              next_state = st_exec;
          endcase
        end
        st_nop:
          if (q == Q_LAST)
            next_state = st_idle;                       // see RULE_15
        default:
          next_state = st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state              <= st_idle;
      ir                 <= 16'h0000;
      ir2                <= 16'h0000;
      ir2_valid          <= 1'b0;
      pc                 <= PC_RST;
      flags              <= FLAGS_RST;
      wreg               <= WREG_RST;
      bank_select_reg    <= BANK_RST;
      working_shadow     <= WREG_RST;
      flags_shadow       <= FLAGS_RST;
      bank_select_shadow <= BANK_RST;
      return_stack_top   <= PC_RST;
      fsr2               <= FSR2_RST;
      ext_en             <= 1'b0;
      wr_pend            <= 1'b0;
      wr_addr            <= 8'h00;
      hrdata             <= 32'h00000000;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      mem_clear_en       <= 1'b0;
      mem_clear_addr     <= 12'h000;
      stack_push         <= 1'b0;
    end
    else
    begin
      state              <= next_state;
      ir                 <= next_ir;
      ir2                <= next_ir2;
      ir2_valid          <= next_ir2_valid;
      pc                 <= next_pc;
      flags              <= next_flags;
      wreg               <= next_wreg;
      bank_select_reg    <= next_bank_select_reg;
      working_shadow     <= next_working_shadow;
      flags_shadow       <= next_flags_shadow;
      bank_select_shadow <= next_bank_select_shadow;
      return_stack_top   <= next_return_stack_top;
      fsr2               <= next_fsr2;
      ext_en             <= next_ext_en;
      wr_pend            <= next_wr_pend;
      wr_addr            <= next_wr_addr;
      if (ce && hsel && htrans[1] && hready && !hwrite)
        hrdata <= next_hrdata;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      mem_clear_en       <= next_mem_clear_en;
      mem_clear_addr     <= next_mem_clear_addr;
      stack_push         <= next_stack_push;
    end
  end

  logic unused_bits;
  assign unused_bits = ^{hsize, haddr[1:0], hwdata[31:16]};
endmodule // branch_call_clear_exec
`default_nettype wire

// [test/branch_call_clear_exec_checker.sv]
/*
  port assertions for the branch, call and clear executor.
  assumes a bind onto branch_call_clear_exec and hready tied to hreadyout.
*/
`default_nettype none
module exec_checker
  import branch_exec_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               ce,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               mem_clear_en,
  input wire logic [FADDR_W-1:0] mem_clear_addr,
  input wire logic               stack_push
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // cycles since the last call or clear word was issued
  logic       ins_dp;
  logic [3:0] call_age;
  logic [3:0] clr_age;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ins_dp   <= 1'b0;
      call_age <= 4'h0;
      clr_age  <= 4'h0;
    end
    else
    begin
      ins_dp   <= hsel && htrans[1] && hready && hwrite
                  && haddr[7:0] == ADDR_INSTR;
      call_age <= (ins_dp && hwdata[15:9] == OP_CALL) ? 4'h1
                  : (call_age != 4'h0 && call_age != 4'hf) ? call_age + 4'h1
                  : call_age;
      clr_age  <= (ins_dp && hwdata[15:9] == OP_CLEAR) ? 4'h1
                  : (clr_age != 4'h0 && clr_age != 4'hf) ? clr_age + 4'h1
                  : clr_age;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_call_issued; call_age == 4'h1; endsequence
  sequence s_clr_issued; clr_age == 4'h1; endsequence
  sequence s_rd_unmapped;
    hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h0
    && haddr[7:0] > ADDR_FSR2;
  endsequence
  property p_ready; hreadyout && !hresp; endproperty
  property p_push_soon; s_call_issued |-> ##[1:5] stack_push; endproperty
  property p_push_cause;
    stack_push |-> call_age != 4'h0 && call_age <= 4'h6;
  endproperty
  property p_push_pulse; stack_push |=> !stack_push; endproperty
  property p_clr_soon; s_clr_issued |-> ##[1:5] mem_clear_en; endproperty
  property p_clr_cause;
    mem_clear_en |-> clr_age != 4'h0 && clr_age <= 4'h6;
  endproperty
  property p_clr_pulse; mem_clear_en |=> !mem_clear_en; endproperty
  property p_clr_addr; !mem_clear_en |-> $stable(mem_clear_addr); endproperty
  property p_unmapped; s_rd_unmapped |=> hrdata == 32'h0; endproperty
  a_ready: assert property (p_ready)
    else $error("bus answer not ready or not okay");
  a_push_soon: assert property (p_push_soon)
    else $error("call gave no return push");
  a_push_cause: assert property (p_push_cause)
    else $error("return push without a call");
  a_push_pulse: assert property (p_push_pulse)
    else $error("return push longer than one cycle");
  a_clr_soon: assert property (p_clr_soon)
    else $error("clear word gave no clear strobe");
  a_clr_cause: assert property (p_clr_cause)
    else $error("clear strobe without a clear word");
  a_clr_pulse: assert property (p_clr_pulse)
    else $error("clear strobe longer than one cycle");
  a_clr_addr: assert property (p_clr_addr)
    else $error("clear address moved without a strobe");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // exec_checker

bind branch_call_clear_exec exec_checker chk (
  .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mem_clear_en(mem_clear_en),
  .mem_clear_addr(mem_clear_addr), .stack_push(stack_push)
);
`default_nettype wire

// [test/tb_branch_call_clear_exec.sv]
/*
  self-checking bench for the branch, call and clear executor.
  assumes one ahb-lite master here and zero-wait answers from the slave.
*/
`default_nettype none
module tb_branch_call_clear_exec
  import branch_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string n; logic [31:0] v;} note_type;
  logic               core_clk, rst_n, ce, hsel, hwrite, hready;
  logic               hreadyout, hresp, mem_clear_en, stack_push;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [FADDR_W-1:0] mem_clear_addr;
  logic [FADDR_W-1:0] cq[$];
  note_type           rq[$];
  note_type           nt;
  logic               rd_dp = 1'b0;
  int                 fails = 0, compares = 0, cyc = 0, pushes = 0;
  assign hready = hreadyout;
  branch_call_clear_exec DUT (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_clear_en(mem_clear_en),
    .mem_clear_addr(mem_clear_addr), .stack_push(stack_push)
  );
  // ==========================================================
  // bus tasks
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input string n, logic [7:0] a, logic [31:0] e);
    rq.push_back('{n, e});
    bus(a, 1'b0, 32'h0);
  endtask
  // ==========================================================
  // output watcher and timeout
  always @(posedge core_clk)
  begin
    if (rd_dp === 1'b1)
    begin
      nt = rq.pop_front();
      chk(nt.n, nt.v, hrdata);
    end
    if (mem_clear_en === 1'b1)
      chk("clear_addr", {20'h0, cq.pop_front()}, {20'h0, mem_clear_addr});
    if (stack_push === 1'b1)
      pushes++;
    rd_dp <= hsel && htrans[1] && hready && !hwrite;
    cyc++;
    if (cyc > 3000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ==========================================================
  // main sequence
  initial
  begin
    logic [PC_W-1:0] p;
    logic [7:0]      n, f, op, w;
    logic [4:0]      fl;
    logic [3:0]      b;
    logic [19:0]     k;
    logic [11:0]     x2, e;
    logic [31:0]     sh;
    logic            take;
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sh = 32'h0;
    void'($urandom(78));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 6; i++)
    begin
      op = i[0] ? OP_BR_OV : OP_BR_Z;
      take = i >= 2;
      n = (i == 2) ? 8'h80 : (i == 3) ? 8'h7f : 8'($urandom);
      fl = 5'($urandom);
      fl[i[0] ? FLAG_OV_BIT : FLAG_Z_BIT] = take;
      p = PC_W'($urandom) & ~PC_W'(1);
      wr(ADDR_PC, {11'h0, p});
      wr(ADDR_STATUS, {27'h0, fl});
      wr(ADDR_INSTR, {16'h0, op, n});
      // clock enable low must hold the instruction in place
      ce <= 1'b0;
      repeat (5) @(posedge core_clk);
      ce <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd("br_status", ADDR_STATUS, {23'h0, take, 3'h0, fl});
      repeat (4) @(posedge core_clk);
      rd("br_pc", ADDR_PC, {11'h0, p + PC_STEP
         + (take ? {{12{n[7]}}, n, 1'b0} : 21'h0)});
    end
    for (int s = 1; s >= 0; s--)
    begin
      p = PC_W'($urandom) & ~PC_W'(1);
      w = 8'($urandom);
      b = 4'($urandom);
      fl = 5'($urandom);
      k = 20'($urandom);
      wr(ADDR_PC, {11'h0, p});
      wr(ADDR_WREG, {24'h0, w});
      wr(ADDR_BANK, {28'h0, b});
      wr(ADDR_STATUS, {27'h0, fl});
      if (s == 1)
        sh = {12'h0, b, 3'h0, fl, w};
      wr(ADDR_INSTR, {16'h0, OP_CALL, s[0], k[7:0]});
      repeat (3) @(posedge core_clk);
      rd("call_wait", ADDR_STATUS, {22'h0, 2'b11, 3'h0, fl});
      wr(ADDR_INSTR, {16'h0, OP_CALL2, k[19:8]});
      repeat (8) @(posedge core_clk);
      rd("call_pc", ADDR_PC, {11'h0, k, 1'b0});
      rd("call_stack", ADDR_STACK, {11'h0, p + 21'h4});
      rd("call_shadow", ADDR_SHADOW, sh);
      rd("call_status", ADDR_STATUS, {27'h0, fl});
    end
    for (int i = 0; i < 5; i++)
    begin
      f = (i == 2) ? IDX_MAX : (i == 3) ? ACCESS_SPLIT : 8'($urandom);
      f = (i == 1) ? f | 8'h80 : (i == 4) ? f & 8'h3f : f;
      b = 4'($urandom);
      x2 = 12'($urandom);
      fl = 5'($urandom) & ~(5'h1 << FLAG_Z_BIT);
      case (i)
        0: e = {b, f};
        2: e = x2 + 12'(f);
        4: e = {4'h0, f};
        default: e = {ACCESS_HI_BANK, f};
      endcase
      wr(ADDR_CTRL, {31'h0, i == 2 || i == 3});
      wr(ADDR_FSR2, {20'h0, x2});
      wr(ADDR_BANK, {28'h0, b});
      wr(ADDR_STATUS, {27'h0, fl});
      cq.push_back(e);
      wr(ADDR_INSTR, {16'h0, OP_CLEAR, i == 0, f});
      repeat (4) @(posedge core_clk);
      rd("clr_status", ADDR_STATUS, {27'h0, fl | 5'h04});
    end
    rd("unmapped", 8'h24, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("push_count", 32'h2, 32'(pushes));
    chk("clear_left", 32'h0, 32'(cq.size()));
    results();
  end
endmodule // tb_branch_call_clear_exec
`default_nettype wire
